/* File: core/dbts_pkg.sv */
package dbts_pkg;

    // bus and chain geometry
    localparam int GROUP_BITS = 9;
    localparam int BUS_BITS   = 2 * GROUP_BITS;
    localparam int CHAIN_LEN  = 80;
    localparam int IR_LEN     = 8;

    // instruction codes, msb first
    localparam logic [7:0] INSTR_EXTEST = 8'h00;
    localparam logic [7:0] INSTR_SAMPLE = 8'h81;
    localparam logic [7:0] INSTR_CLAMP  = 8'h82;
    localparam logic [7:0] INSTR_HIGHZ  = 8'h03;
    localparam logic [7:0] INSTR_RESET  = 8'hff;

    // fixed low bits of the instruction capture pattern and the bypass capture value
    localparam logic [1:0] IR_CAPTURE_LSBS = 2'h1;
    localparam logic       BYPASS_CAPTURE  = 1'h0;

    // control cell positions in the chain
    localparam int POS_DIR_ONE  = 79;
    localparam int POS_ENB_ONE  = 78;
    localparam int POS_AEN_ONE  = 77;
    localparam int POS_BEN_ONE  = 76;
    localparam int POS_DIR_TWO  = 75;
    localparam int POS_ENB_TWO  = 74;
    localparam int POS_AEN_TWO  = 73;
    localparam int POS_BEN_TWO  = 72;
    // data field bases (lowest position of each 18-cell field)
    localparam int BASE_A_IN    = 54;
    localparam int BASE_B_OUT   = 36;
    localparam int BASE_B_IN    = 18;
    localparam int BASE_A_OUT   = 0;

    // register map
    localparam logic [31:0] OFFS_CTRL   = 32'h0000_0000;
    localparam logic [31:0] OFFS_STATUS = 32'h0000_0004;
    localparam int          CTRL_HOLD_BIT  = 0;
    localparam logic        CTRL_HOLD_RESET = 1'h0;
    localparam int          STAT_INSTR_LSB = 16;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [15:0] {
        TAP_RESET    = 16'h0001,
        TAP_IDLE     = 16'h0002,
        TAP_SEL_DR   = 16'h0004,
        TAP_CAP_DR   = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EX1_DR   = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EX2_DR   = 16'h0080,
        TAP_UPD_DR   = 16'h0100,
        TAP_SEL_IR   = 16'h0200,
        TAP_CAP_IR   = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EX1_IR   = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EX2_IR   = 16'h4000,
        TAP_UPD_IR   = 16'h8000
    } dbts_tap_state_t;

endpackage

/* File: core/dbts_transceiver.sv */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module dbts_transceiver
    import dbts_pkg::*;
#(
    // arbitrary neutral value, not tied to any real part
    parameter logic [5:0] PSEUDO_ID = 6'h2a
)(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // register bus
    input  wire logic [31:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [31:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // test access port
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    output logic                     tdo,
    output logic                     tdo_oe,
    // group controls
    input  wire logic                enable_bar_group_one,
    input  wire logic                enable_bar_group_two,
    input  wire logic                flow_select_group_one,
    input  wire logic                flow_select_group_two,
    // data sides, group one in bits 8:0, group two in bits 17:9
    input  wire logic [BUS_BITS-1:0] side_a_in,
    output logic [BUS_BITS-1:0]      side_a_out,
    output logic [BUS_BITS-1:0]      side_a_oe,
    input  wire logic [BUS_BITS-1:0] side_b_in,
    output logic [BUS_BITS-1:0]      side_b_out,
    output logic [BUS_BITS-1:0]      side_b_oe
);

    // group bit 0 of group one lands on the highest cell of a field
    function automatic logic [BUS_BITS-1:0] flip(input logic [BUS_BITS-1:0] v);
        logic [BUS_BITS-1:0] r;
        r = '0;
        for (int i = 0; i < BUS_BITS; i++)
            r[BUS_BITS-1-i] = v[i];
        return r;
    endfunction

    // synchronisers: stage one feeds stage two only
    logic [2:0]          tap_s1;
    logic [2:0]          tap_s2;
    logic                tck_d;
    logic [3:0]          ctl_s1;
    logic [3:0]          ctl_s2;
    logic [BUS_BITS-1:0] a_s1;
    logic [BUS_BITS-1:0] a_s2;
    logic [BUS_BITS-1:0] b_s1;
    logic [BUS_BITS-1:0] b_s2;

    always_ff @(posedge clk)
    begin
        tap_s1 <= {tdi, tms, tck};
        tap_s2 <= tap_s1;
        tck_d  <= tap_s2[0];
        ctl_s1 <= {flow_select_group_two, enable_bar_group_two,
                   flow_select_group_one, enable_bar_group_one};
        ctl_s2 <= ctl_s1;
        a_s1   <= side_a_in;
        a_s2   <= a_s1;
        b_s1   <= side_b_in;
        b_s2   <= b_s1;
    end

    wire       tck_rise = tap_s2[0] & ~tck_d;
    wire       tck_fall = ~tap_s2[0] & tck_d;
    wire       tms_s    = tap_s2[1];
    wire       tdi_s    = tap_s2[2];
    wire [1:0] enb_s    = {ctl_s2[2], ctl_s2[0]};
    wire [1:0] dir_s    = {ctl_s2[3], ctl_s2[1]};

    // register file state
    logic            hold_reset;
    dbts_tap_state_t state;
    dbts_tap_state_t next_state;
    logic [IR_LEN-1:0]    ir;
    logic [IR_LEN-1:0]    ir_sh;
    logic [CHAIN_LEN-1:0] boundary_cell_chain;
    logic [CHAIN_LEN-1:0] upd;
    logic                 byp;

    // controller sequencing on tms
    always_comb
    begin
        next_state = state;
        case (state)
            TAP_RESET:    next_state = tms_s ? TAP_RESET   : TAP_IDLE;
            TAP_IDLE:     next_state = tms_s ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_DR:   next_state = tms_s ? TAP_SEL_IR  : TAP_CAP_DR;
            TAP_CAP_DR:   next_state = tms_s ? TAP_EX1_DR  : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_state = tms_s ? TAP_EX1_DR  : TAP_SHIFT_DR;
            TAP_EX1_DR:   next_state = tms_s ? TAP_UPD_DR  : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_state = tms_s ? TAP_EX2_DR  : TAP_PAUSE_DR;
            TAP_EX2_DR:   next_state = tms_s ? TAP_UPD_DR  : TAP_SHIFT_DR;
            TAP_UPD_DR:   next_state = tms_s ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_IR:   next_state = tms_s ? TAP_RESET   : TAP_CAP_IR;
            TAP_CAP_IR:   next_state = tms_s ? TAP_EX1_IR  : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_state = tms_s ? TAP_EX1_IR  : TAP_SHIFT_IR;
            TAP_EX1_IR:   next_state = tms_s ? TAP_UPD_IR  : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_state = tms_s ? TAP_EX2_IR  : TAP_PAUSE_IR;
            TAP_EX2_IR:   next_state = tms_s ? TAP_UPD_IR  : TAP_SHIFT_IR;
            TAP_UPD_IR:   next_state = tms_s ? TAP_SEL_DR  : TAP_IDLE;
            default:      next_state = TAP_RESET;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst || hold_reset)
            state <= TAP_RESET;
        else if (tck_rise)
            state <= next_state;
    end

    // instruction decode; anything unlisted selects bypass
    wire sel_extest = (ir == INSTR_EXTEST);
    wire sel_sample = (ir == INSTR_SAMPLE);
    wire sel_clamp  = (ir == INSTR_CLAMP);
    wire sel_highz  = (ir == INSTR_HIGHZ);
    wire sel_bsr    = sel_extest | sel_sample;
    wire test_drive = sel_extest | sel_clamp;

    // system logic enables and data
    wire [1:0]          a_en_sys   = ~enb_s & ~dir_s;
    wire [1:0]          b_en_sys   = ~enb_s & dir_s;
    wire [BUS_BITS-1:0] a_data_sys = b_s2;
    wire [BUS_BITS-1:0] b_data_sys = a_s2;

    // observe-only cells only sample, the data path never reads them
    wire [CHAIN_LEN-1:0] capture_vec = {
        dir_s[0], enb_s[0], a_en_sys[0], b_en_sys[0],
        dir_s[1], enb_s[1], a_en_sys[1], b_en_sys[1],
        flip(a_s2), flip(b_data_sys), flip(b_s2), flip(a_data_sys)};

    // update stages take over in extest and clamp; highz floats all
    wire [1:0] a_en_eff = sel_highz ? 2'h0 :
                          test_drive ? {upd[POS_AEN_TWO], upd[POS_AEN_ONE]} : a_en_sys;
    wire [1:0] b_en_eff = sel_highz ? 2'h0 :
                          test_drive ? {upd[POS_BEN_TWO], upd[POS_BEN_ONE]} : b_en_sys;
    wire [BUS_BITS-1:0] a_data_eff = test_drive ?
                          flip(upd[BASE_A_OUT +: BUS_BITS]) : a_data_sys;
    wire [BUS_BITS-1:0] b_data_eff = test_drive ?
                          flip(upd[BASE_B_OUT +: BUS_BITS]) : b_data_sys;

    // pins come from flops, costing one clk after the synchronisers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            side_a_out <= '0;
            side_b_out <= '0;
            side_a_oe  <= '0;
            side_b_oe  <= '0;
        end
        else
        begin
            side_a_out <= a_data_eff;
            side_b_out <= b_data_eff;
            side_a_oe  <= {{GROUP_BITS{a_en_eff[1]}}, {GROUP_BITS{a_en_eff[0]}}};
            side_b_oe  <= {{GROUP_BITS{b_en_eff[1]}}, {GROUP_BITS{b_en_eff[0]}}};
        end
    end

    // data registers and the instruction shift register capture and shift on tck rise
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            boundary_cell_chain   <= '0;
            byp   <= 1'h0;
            ir_sh <= '0;
        end
        else if (tck_rise)
        begin
            if (state == TAP_CAP_DR)
            begin
                boundary_cell_chain <= sel_bsr ? capture_vec : boundary_cell_chain;
                byp <= BYPASS_CAPTURE;
            end
            else if (state == TAP_SHIFT_DR)
            begin
                boundary_cell_chain <= sel_bsr ? {tdi_s, boundary_cell_chain[CHAIN_LEN-1:1]} : boundary_cell_chain;
                byp <= tdi_s;
            end
            if (state == TAP_CAP_IR)
                ir_sh <= {PSEUDO_ID, IR_CAPTURE_LSBS};
            else if (state == TAP_SHIFT_IR)
                ir_sh <= {tdi_s, ir_sh[IR_LEN-1:1]};
        end
    end

    // updates and tdo move on tck fall
    always_ff @(posedge clk)
    begin
        if (rst || state == TAP_RESET)
            ir <= INSTR_RESET;
        else if (tck_fall && state == TAP_UPD_IR)
            ir <= ir_sh;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            upd <= '0;
        else if (tck_fall && state == TAP_UPD_DR && sel_bsr)
            upd <= boundary_cell_chain;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end
        else if (tck_fall)
        begin
            tdo_oe <= (state == TAP_SHIFT_IR) || (state == TAP_SHIFT_DR);
            if (state == TAP_SHIFT_IR)
                tdo <= ir_sh[0];
            else if (state == TAP_SHIFT_DR)
                tdo <= sel_bsr ? boundary_cell_chain[0] : byp;
        end
    end

    // register bus slave; write answer waits until both halves are in
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_got;
    logic        w_got;

    wire aw_hs   = s_axi_awvalid & s_axi_awready;
    wire w_hs    = s_axi_wvalid & s_axi_wready;
    wire ar_hs   = s_axi_arvalid & s_axi_arready;
    wire wr_fire = aw_got & w_got & ~s_axi_bvalid;
    wire wr_ctrl = (aw_addr == OFFS_CTRL);
    wire rd_ctrl = (s_axi_araddr == OFFS_CTRL);
    wire rd_stat = (s_axi_araddr == OFFS_STATUS);
    wire [31:0] stat_word = {8'h00, ir, 16'(state)};
    wire [31:0] rd_word   = rd_ctrl ? {31'h0, hold_reset} :
                            rd_stat ? stat_word : 32'h0;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'h1;
            s_axi_wready  <= 1'h1;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got        <= 1'h0;
            w_got         <= 1'h0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            hold_reset    <= CTRL_HOLD_RESET;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_addr       <= s_axi_awaddr;
                aw_got        <= 1'h1;
                s_axi_awready <= 1'h0;
            end
            if (w_hs)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_got        <= 1'h1;
                s_axi_wready <= 1'h0;
            end
            if (wr_fire)
            begin
                aw_got        <= 1'h0;
                w_got         <= 1'h0;
                s_axi_awready <= 1'h1;
                s_axi_wready  <= 1'h1;
                s_axi_bvalid  <= 1'h1;
                s_axi_bresp   <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl && w_strb[0])
                    hold_reset <= w_data[CTRL_HOLD_BIT];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid  <= 1'h1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'h0;
            s_axi_arready <= 1'h1;
        end
    end

    // checks
    logic [2:0] tms_ones;
    always_ff @(posedge clk)
    begin
        if (rst)
            tms_ones <= 3'h0;
        else if (tck_rise)
            tms_ones <= !tms_s ? 3'h0 : (tms_ones == 3'h5) ? 3'h5 : tms_ones + 3'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    normal_a_drive_a: assert property ((ir == INSTR_RESET && !enb_s[0] && !dir_s[0])
        |=> (side_a_oe[0] && !side_b_oe[0] && side_a_out[8:0] == $past(b_s2[8:0])))
        else $error("group one A side not driven from B side");
    normal_b_drive_a: assert property ((ir == INSTR_RESET && !enb_s[1] && dir_s[1])
        |=> (side_b_oe[9] && !side_a_oe[9] && side_b_out[17:9] == $past(a_s2[17:9])))
        else $error("group two B side not driven from A side");
    disabled_float_a: assert property ((ir == INSTR_RESET && enb_s[0])
        |=> (side_a_oe[8:0] == 9'h0 && side_b_oe[8:0] == 9'h0))
        else $error("disabled group still drives");
    highz_float_a: assert property (sel_highz
        |=> (side_a_oe == '0 && side_b_oe == '0))
        else $error("highz left outputs driven");
    clamp_drive_a: assert property ((sel_clamp || sel_extest)
        |=> (side_b_oe[0] == $past(upd[POS_BEN_ONE])
             && side_a_out[0] == $past(upd[BASE_A_OUT + BUS_BITS - 1])))
        else $error("update stage did not steer outputs");
    bypass_capture_a: assert property ((tck_rise && state == TAP_CAP_DR)
        |=> (byp == 1'h0))
        else $error("bypass did not capture zero");
    ir_capture_a: assert property ((tck_rise && state == TAP_CAP_IR)
        |=> (ir_sh[1:0] == 2'h1 && ir_sh[7:2] == PSEUDO_ID))
        else $error("instruction capture pattern wrong");
    tdo_falling_a: assert property ($changed(tdo) |-> $past(tck_fall))
        else $error("tdo moved away from a tck fall");
    five_ones_a: assert property ((tms_ones == 3'h5) |-> (state == TAP_RESET))
        else $error("five tms-high clocks did not reach reset");

    extest_seen_c: cover property (sel_extest ##1 side_b_oe[0]);
    clamp_seen_c:  cover property (sel_clamp && state == TAP_SHIFT_DR && tck_rise);
    reset_walk_c:  cover property ((state == TAP_SHIFT_DR) ##[1:200] (state == TAP_RESET));

endmodule

/* File: testbench/dbts_tap_host.sv */
`timescale 1ns/1ps

module dbts_tap_host (
    // test access port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // tck parks low between operations
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    // one 400 ns period; tdo is read late in the high phase, clear of the next fall
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #200;
        tck = 1'h1;
        #200;
        q = tdo;
        tck = 1'h0;
    endtask

    task automatic reset5();
        logic q;
        repeat (5) step(1'h1, 1'h0, q);
    endtask

    // from reset or idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [79:0] din,
                        output logic [79:0] dout);
        logic q;
        dout = '0;
        step(1'h0, 1'h0, q);
        step(1'h1, 1'h0, q);
        if (ir)
            step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
        step(1'h0, 1'h0, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
    endtask
endmodule

/* File: testbench/dbts_transceiver_test.sv */
`timescale 1ns/1ps

module dbts_transceiver_test;
    import dbts_pkg::*;

    // arbitrary pseudo id, not tied to any real part
    localparam logic [5:0] TB_ID = 6'h15;

    logic        clk, rst, tck, tms, tdi, tdo, tdo_oe;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        enb_one, enb_two, flow_one, flow_two;
    logic [17:0] ext_a, ext_b, side_a_in, side_b_in, side_a_out, side_a_oe, side_b_out, side_b_oe;
    logic [79:0] pat, dout;
    logic [7:0]  code;
    int          miscompares, cmp_count;

    // pin level: the transceiver wins where it drives, else the outside agent
    assign side_a_in = (side_a_oe & side_a_out) | (~side_a_oe & ext_a);
    assign side_b_in = (side_b_oe & side_b_out) | (~side_b_oe & ext_b);
    wire logic [17:0] ga = {{9{~enb_two & ~flow_two}}, {9{~enb_one & ~flow_one}}};
    wire logic [17:0] gb = {{9{~enb_two & flow_two}}, {9{~enb_one & flow_one}}};
    wire logic [17:0] pa = (ga & ext_b) | (~ga & ext_a);
    wire logic [17:0] pb = (gb & ext_a) | (~gb & ext_b);

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    dbts_tap_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    dbts_transceiver #(.PSEUDO_ID(TB_ID)) dut (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .enable_bar_group_one(enb_one), .enable_bar_group_two(enb_two),
        .flow_select_group_one(flow_one), .flow_select_group_two(flow_two),
        .side_a_in(side_a_in), .side_a_out(side_a_out), .side_a_oe(side_a_oe),
        .side_b_in(side_b_in), .side_b_out(side_b_out), .side_b_oe(side_b_oe)
    );

    task automatic check_vec(input string nm, input logic [79:0] e, input logic [79:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic limit(input int n);
        if (n >= 50)
        begin
            miscompares++;
            $display("ERROR bus_wait expected answer seen none");
            end_sim();
        end
    endtask

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        limit(n);
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        limit(n);
    endtask

    // tck edges sit 7 ns after a clk edge so the two clocks never coincide
    task automatic tap_scan(input logic ir, input int n, input logic [79:0] din);
        @(posedge clk);
        #7;
        host.scan(ir, n, din, dout);
    endtask

    // the pins loop back into the inputs, so a turn-around needs two trips through the synchronisers
    task automatic check_normal();
        repeat (7) @(posedge clk);
        check_vec("a_oe", ga, side_a_oe);
        check_vec("a_out", ga & ext_b, ga & side_a_out);
        check_vec("b_oe", gb, side_b_oe);
        check_vec("b_out", gb & ext_a, gb & side_b_out);
    endtask

    task automatic check_drive(input logic hz);
        logic [17:0] ao, bo, ea, eb;
        for (int k = 0; k < 18; k++)
        begin
            ao[k] = pat[17 - k];
            bo[k] = pat[53 - k];
        end
        ea = hz ? 18'h0 : {{9{pat[73]}}, {9{pat[77]}}};
        eb = hz ? 18'h0 : {{9{pat[72]}}, {9{pat[76]}}};
        repeat (4) @(posedge clk);
        check_vec("test_a_oe", ea, side_a_oe);
        check_vec("test_a_out", ea & ao, ea & side_a_out);
        check_vec("test_b_oe", eb, side_b_oe);
        check_vec("test_b_out", eb & bo, eb & side_b_out);
    endtask

    // own bits, so the preloaded pattern stays intact for the drive checks
    task automatic check_bypass(input string nm);
        logic [5:0] v;
        v = 6'($urandom);
        tap_scan(1'h0, 6, {74'h0, v});
        check_vec(nm, {v[4:0], 1'h0}, dout[5:0]);
        check_vec("tdo_oe_idle", 1'h0, tdo_oe);
    endtask

    function automatic logic [79:0] exp_chain();
        logic [79:0] c;
        c[79:72] = {flow_one, enb_one, ga[0], gb[0], flow_two, enb_two, ga[9], gb[9]};
        for (int k = 0; k < 18; k++)
        begin
            c[71 - k] = pa[k];
            c[53 - k] = pa[k];
            c[35 - k] = pb[k];
            c[17 - k] = pb[k];
        end
        return c;
    endfunction

    initial
    begin
        rst = 1'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {enb_one, enb_two, flow_one, flow_two} = 4'hc;
        {ext_a, ext_b} = 36'h0;
        miscompares = 0;
        cmp_count = 0;
        void'($urandom(32'hd3cf56c3));
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        axi_read(OFFS_STATUS, rd, rsp);
        check_vec("status", {8'hff, 16'h0001}, rd[23:0]);
        axi_read(32'h10, rd, rsp);
        check_resp("unmapped_read", RESP_SLVERR, rsp);
        check_vec("unmapped_data", 32'h0, rd);
        axi_write(OFFS_STATUS, 32'h1, rsp);
        check_resp("status_write", RESP_SLVERR, rsp);
        $display("test registers done");
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clk);
            {enb_one, flow_one} <= i[1:0];
            {enb_two, flow_two} <= 2'($urandom);
            ext_a <= 18'($urandom);
            ext_b <= 18'($urandom);
            check_normal();
        end
        $display("test normal done");
        tap_scan(1'h1, 8, {72'h0, INSTR_SAMPLE});
        check_vec("ir_capture", {TB_ID, IR_CAPTURE_LSBS}, dout[7:0]);
        for (int j = 0; j < 3; j++)
        begin
            @(posedge clk);
            {enb_one, flow_one, enb_two, flow_two} <= 4'($urandom);
            ext_a <= 18'($urandom);
            ext_b <= 18'($urandom);
            repeat (4) @(posedge clk);
            tap_scan(1'h0, 80, 80'h0);
            check_vec("chain", exp_chain(), dout);
            check_normal();
        end
        $display("test sample done");
        pat = {16'($urandom), $urandom, $urandom};
        pat[77:76] = 2'h3;
        tap_scan(1'h0, 80, pat);
        tap_scan(1'h1, 8, {72'h0, INSTR_EXTEST});
        check_drive(1'h0);
        tap_scan(1'h1, 8, {72'h0, INSTR_CLAMP});
        check_bypass("clamp_bypass");
        check_drive(1'h0);
        tap_scan(1'h1, 8, {72'h0, INSTR_HIGHZ});
        check_bypass("highz_bypass");
        check_drive(1'h1);
        $display("test instructions done");
        for (int j = 0; j < 3; j++)
        begin
            code = 8'($urandom) | 8'h40;
            tap_scan(1'h1, 8, {72'h0, code});
            check_bypass("other_bypass");
            check_normal();
        end
        tap_scan(1'h1, 8, {72'h0, INSTR_EXTEST});
        @(posedge clk);
        #7;
        host.reset5();
        check_normal();
        axi_read(OFFS_STATUS, rd, rsp);
        check_vec("reset_status", {8'hff, 16'h0001}, rd[23:0]);
        axi_write(OFFS_CTRL, 32'h1, rsp);
        check_resp("ctrl_write", RESP_OKAY, rsp);
        tap_scan(1'h1, 8, {72'h0, INSTR_SAMPLE});
        axi_read(OFFS_STATUS, rd, rsp);
        check_vec("held_status", {8'hff, 16'h0001}, rd[23:0]);
        axi_read(OFFS_CTRL, rd, rsp);
        check_vec("ctrl_read", 32'h1, rd);
        axi_write(OFFS_CTRL, 32'h0, rsp);
        check_resp("ctrl_release", RESP_OKAY, rsp);
        $display("test tap reset done");
        end_sim();
    end
endmodule
